// >>> design/rxfa_defines.vh
`ifndef RXFA_DEFINES_VH
`define RXFA_DEFINES_VH
// ****************************************
// register offsets
// ****************************************
`define RXFA_IDX_IRQ_EN      8'h12
`define RXFA_IDX_IRQ_ST      8'h13
`define RXFA_IDX_CODE        8'h16
`define RXFA_IDX_MSG_CTRL    8'h17
`define RXFA_IDX_W           8
// ****************************************
// field positions and values
// ****************************************
`define RXFA_BIT_CP          7
`define RXFA_BIT_VST         0
`define RXFA_BIT_VEN         1
`define RXFA_BIT_RST         2
`define RXFA_BIT_REN         3
`define RXFA_BIT_HELD        4
`define RXFA_RESET_BYTE      8'h00
`define RXFA_CODE_W          6
`define RXFA_HIST_LEN        10
`define RXFA_VALID_CNT       4'h8
`define RXFA_REMOVE_CNT      4'h3
`define RXFA_HTRANS_NONSEQ   2'h2
`define RXFA_HSIZE_WORD      3'h2
`endif

// >>> design/rxfa_msg_proc.v
`timescale 1ns/10ps
`include "rxfa_defines.vh"
// ****************************************
// alarm message validate and remove
// ****************************************
module rxfa_msg_proc (
    // clock and reset
    input  wire                     ref_clk,
    input  wire                     rstn,
    // received messages
    input  wire                     msg_stb,
    input  wire [`RXFA_CODE_W-1:0]  msg_code,
    // results
    output reg                      held_reg,
    output reg  [`RXFA_CODE_W-1:0]  code_reg,
    output reg                      valid_pulse,
    output reg                      remove_pulse
);
    localparam HL = `RXFA_HIST_LEN;
    reg [`RXFA_CODE_W-1:0] hist [0:HL-1];
    // only filled slots count after reset
    reg [HL-1:0]           hist_vld_reg;
    reg [3:0]              same_cnt;
    reg [3:0]              diff_cnt;
    integer                i;
    // counts include the new reception
    always @* begin
        same_cnt = 4'h1;
        diff_cnt = 4'h0;
        for (i = 0; i < HL-1; i = i + 1) begin
            if (hist_vld_reg[i] && hist[i] == msg_code) begin
                same_cnt = same_cnt + 4'h1;
            end
            if (hist_vld_reg[i] && hist[i] != code_reg) begin
                diff_cnt = diff_cnt + 4'h1;
            end
        end
        if (msg_code != code_reg) begin
            diff_cnt = diff_cnt + 4'h1;
        end
    end
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < HL; i = i + 1) begin
                hist[i] <= {`RXFA_CODE_W{1'b0}};
            end
            hist_vld_reg <= {HL{1'b0}};
            held_reg     <= 1'b0;
            code_reg     <= {`RXFA_CODE_W{1'b0}};
            valid_pulse  <= 1'b0;
            remove_pulse <= 1'b0;
        end else begin
            valid_pulse  <= 1'b0;
            remove_pulse <= 1'b0;
            if (msg_stb) begin
                hist[0] <= msg_code;
                hist_vld_reg <= {hist_vld_reg[HL-2:0], 1'b1};
                for (i = 1; i < HL; i = i + 1) begin
                    hist[i] <= hist[i-1];
                end
                if (held_reg) begin
                    if (diff_cnt >= `RXFA_REMOVE_CNT) begin
                        held_reg     <= 1'b0;
                        code_reg     <= {`RXFA_CODE_W{1'b0}};
                        remove_pulse <= 1'b1;
                    end
                end else if (same_cnt >= `RXFA_VALID_CNT) begin
                    held_reg    <= 1'b1;
                    code_reg    <= msg_code;
                    valid_pulse <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> design/rxfa_pin_sync.v
`timescale 1ns/10ps
// ****************************************
// three-stage synchroniser, changes on agree
// ****************************************
module rxfa_pin_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         rstn,
    // data
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule

// >>> design/rxfa_top.v
`timescale 1ns/10ps
`include "rxfa_defines.vh"
module rxfa_top (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // framer events, from pins
    input  wire        cp_err_in,
    input  wire        msg_stb_in,
    input  wire [5:0]  msg_code_in,
    // interrupt request, high active
    output reg         irq_out
);
    // ****************************************
    // input synchronisers
    // ****************************************
    wire [7:0] sync_q;
    rxfa_pin_sync #(.W(8)) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .din     ({cp_err_in, msg_stb_in, msg_code_in}),
        .dout    (sync_q)
    );
    reg        cp_d_reg;
    reg        stb_d_reg;
    wire       cp_rise  = sync_q[7] & ~cp_d_reg;
    wire       stb_rise = sync_q[6] & ~stb_d_reg;
    wire       held;
    wire [5:0] code;
    wire       v_pulse;
    wire       r_pulse;
    rxfa_msg_proc u_proc (
        .ref_clk      (ref_clk),
        .rstn         (rstn),
        .msg_stb      (stb_rise),
        // code and strobe leave the synchroniser together
        .msg_code     (sync_q[5:0]),
        .held_reg     (held),
        .code_reg     (code),
        .valid_pulse  (v_pulse),
        .remove_pulse (r_pulse)
    );
    // ****************************************
    // ahb-lite bus slave
    // ****************************************
    reg        ph_wr_reg;
    reg        ph_rd_reg;
    reg  [7:0] ph_idx_reg;
    reg  [7:0] en_reg;
    reg        cp_st_reg;
    reg        ven_reg;
    reg        ren_reg;
    reg        vst_reg;
    reg        rst_reg;
    wire       take = hsel & hready & htrans[1];
    wire [7:0] idx  = haddr[9:2];
    wire       rd_st  = ph_rd_reg & (ph_idx_reg == `RXFA_IDX_IRQ_ST);
    wire       rd_msg = ph_rd_reg & (ph_idx_reg == `RXFA_IDX_MSG_CTRL);
    reg  [7:0] rd_byte;
    always @* begin
        rd_byte = `RXFA_RESET_BYTE;
        case (idx)
            `RXFA_IDX_IRQ_EN:   rd_byte = en_reg;
            `RXFA_IDX_IRQ_ST:   rd_byte = {cp_st_reg, 7'h00};
            `RXFA_IDX_CODE:     rd_byte = {1'b0, code, 1'b0};
            `RXFA_IDX_MSG_CTRL: rd_byte = {3'h0, held, ren_reg, rst_reg,
                                           ven_reg, vst_reg};
            default:            rd_byte = `RXFA_RESET_BYTE;
        endcase
    end
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ph_wr_reg  <= 1'b0;
            ph_rd_reg  <= 1'b0;
            ph_idx_reg <= 8'h00;
            hrdata     <= 32'h00000000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            cp_d_reg   <= 1'b0;
            stb_d_reg  <= 1'b0;
        end else begin
            cp_d_reg   <= sync_q[7];
            stb_d_reg  <= sync_q[6];
            if (hready) begin
                ph_wr_reg  <= take & hwrite;
                ph_rd_reg  <= take & ~hwrite;
                ph_idx_reg <= idx;
                if (take & ~hwrite) begin
                    hrdata <= {24'h000000, rd_byte};
                end
            end
        end
    end
    // ****************************************
    // registers and status
    // ****************************************
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            en_reg    <= `RXFA_RESET_BYTE;
            ven_reg   <= 1'b0;
            ren_reg   <= 1'b0;
            cp_st_reg <= 1'b0;
            vst_reg   <= 1'b0;
            rst_reg   <= 1'b0;
            irq_out   <= 1'b0;
        end else begin
            if (ph_wr_reg && ph_idx_reg == `RXFA_IDX_IRQ_EN) begin
                en_reg <= hwdata[7:0];
            end
            if (ph_wr_reg && ph_idx_reg == `RXFA_IDX_MSG_CTRL) begin
                ven_reg <= hwdata[`RXFA_BIT_VEN];
                ren_reg <= hwdata[`RXFA_BIT_REN];
            end
            if (cp_rise & en_reg[`RXFA_BIT_CP]) begin
                cp_st_reg <= 1'b1;
            end else if (rd_st) begin
                cp_st_reg <= 1'b0;
            end
            if (v_pulse & ven_reg) begin
                vst_reg <= 1'b1;
            end else if (rd_msg) begin
                vst_reg <= 1'b0;
            end
            if (r_pulse & ren_reg) begin
                rst_reg <= 1'b1;
            end else if (rd_msg) begin
                rst_reg <= 1'b0;
            end
            irq_out <= cp_st_reg | vst_reg | rst_reg;
        end
    end
endmodule

// >>> sim/rxfa_top_bench.sv
`timescale 1ns/10ps
module rxfa_top_bench;
    reg         ref_clk, rstn, hsel, hwrite, cp_err_in, msg_stb_in;
    reg  [31:0] haddr, hwdata, rnd, rd, wd;
    reg  [1:0]  htrans;
    reg  [5:0]  msg_code_in, code_m, cx, cz;
    reg  [5:0]  hist[$];
    reg         held_m, vst_m, rst_m;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, irq_out;
    integer     n_mismatch, check_count, i;
    rxfa_top i_rxfa_top (
        .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cp_err_in(cp_err_in), .msg_stb_in(msg_stb_in),
        .msg_code_in(msg_code_in), .irq_out(irq_out));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [31:0] e, input [31:0] s, input string nm);
        begin
            check_count++;
            if (s !== e) begin
                $display("Error %s exp %h got %h", nm, e, s);
                n_mismatch++;
            end
        end
    endtask
    task rdy;
        integer k;
        begin
            k = 0;
            @(posedge ref_clk);
            while (hreadyout !== 1'b1 && k < 20) begin
                @(posedge ref_clk);
                k++;
            end
            if (k == 20) begin
                n_mismatch++;
                stop_test;
            end
        end
    endtask
    task bus(input w, input [9:0] a, input [31:0] d, output [31:0] r);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {22'h0, a};
            rdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            rdy;
            r = hrdata;
        end
    endtask
    task cp_event;
        begin
            cp_err_in <= 1'b1;
            repeat (4) @(posedge ref_clk);
            cp_err_in <= 1'b0;
            repeat (12) @(posedge ref_clk);
        end
    endtask
    // ****************************************
    // alarm message reception and model
    // ****************************************
    task msg(input [5:0] c);
        integer k, eq, df;
        begin
            msg_code_in <= c;
            @(posedge ref_clk);
            msg_stb_in <= 1'b1;
            repeat (4) @(posedge ref_clk);
            msg_stb_in <= 1'b0;
            repeat (12) @(posedge ref_clk);
            hist.push_back(c);
            if (hist.size() > 10)
                void'(hist.pop_front());
            eq = 0;
            df = 0;
            for (k = 0; k < hist.size(); k++) begin
                eq += (hist[k] == c);
                df += (hist[k] != code_m);
            end
            if (!held_m && eq >= 8) begin
                held_m = 1;
                code_m = c;
                vst_m = 1;
            end else if (held_m && df >= 3) begin
                held_m = 0;
                code_m = 0;
                rst_m = 1;
            end
            chk({31'h0, irq_out}, {31'h0, vst_m | rst_m}, "irq");
            bus(0, 8'h58, 0, rd);
            chk({25'h0, code_m, 1'b0}, rd, "code");
            bus(0, 8'h5C, 0, rd);
            chk({27'h0, held_m, 1'b1, rst_m, 1'b1, vst_m}, rd, "ctrl");
            vst_m = 0;
            rst_m = 0;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rstn, hsel, hwrite, cp_err_in, msg_stb_in} = 5'h00;
        {haddr, hwdata, htrans, msg_code_in} = 0;
        {n_mismatch, check_count, held_m, vst_m, rst_m, code_m} = 0;
        rnd = 32'h79368E84;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        for (i = 8'h40; i < 8'h60; i += 4) begin
            bus(0, i[7:0], 0, rd);
            chk(32'h0, rd, "reset");
        end
        $display("reset test done");
        rnd = xs(rnd);
        wd = {24'h0, rnd[7:0] | 8'h80};
        bus(1, 8'h48, wd, rd);
        bus(0, 8'h48, 0, rd);
        chk(wd, rd, "enable");
        cp_event;
        chk(32'h1, {31'h0, irq_out}, "cp irq");
        bus(0, 8'h4C, 0, rd);
        chk(32'h80, rd, "status");
        bus(0, 8'h4C, 0, rd);
        chk(32'h0, rd, "cleared");
        repeat (2) @(posedge ref_clk);
        chk(32'h0, {31'h0, irq_out}, "irq off");
        // error count lives in the performance monitor, not here
        bus(0, 10'h1C8, 0, rd);
        chk(32'h0, rd, "count lo");
        bus(0, 10'h1CC, 0, rd);
        chk(32'h0, rd, "count hi");
        bus(1, 8'h48, 0, rd);
        cp_event;
        bus(0, 8'h4C, 0, rd);
        chk(32'h0, rd, "masked");
        $display("cp test done");
        bus(1, 8'h5C, 32'h0A, rd);
        rnd = xs(rnd);
        cx = rnd[5:0];
        cz = rnd[11:6];
        for (i = 0; i < 19; i++) begin
            rnd = xs(rnd);
            msg(i < 8 ? cx : i < 11 ? cx ^ {rnd[4:0], 1'b1} : cz);
        end
        $display("message test done");
        stop_test;
    end
endmodule

// >>> sim/rxfa_top_props.sv
`timescale 1ns/10ps
module rxfa_top_chk (
    // clock, reset, bus
    input wire        ref_clk,
    input wire        rstn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // events
    input wire        cp_err_in,
    input wire        msg_stb_in,
    input wire [5:0]  msg_code_in,
    input wire        irq_out
);
    reg       ap_reg, wr_reg, en_cp_reg, en_v_reg, en_r_reg;
    reg [7:0] ad_reg;
    wire      rd = ap_reg && !wr_reg;
    wire      wr = ap_reg && wr_reg;
    // shadow of the enables seen on the bus
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ap_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            ad_reg    <= 8'h00;
            en_cp_reg <= 1'b0;
            en_v_reg  <= 1'b0;
            en_r_reg  <= 1'b0;
        end else begin
            ap_reg <= hsel && hready && htrans[1];
            wr_reg <= hwrite;
            ad_reg <= haddr[7:0];
            if (wr && ad_reg == 8'h48)
                en_cp_reg <= hwdata[7];
            if (wr && ad_reg == 8'h5C) begin
                en_v_reg <= hwdata[1];
                en_r_reg <= hwdata[3];
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_cp; $rose(cp_err_in) && en_cp_reg; endsequence
    sequence s_rd(a); rd && ad_reg == a; endsequence
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bad bus answer");
    property p_cp_irq; s_cp |-> ##[3:10] irq_out; endproperty
    a_cp_irq: assert property (p_cp_irq) else $error("no irq");
    property p_irq_cause; $rose(irq_out) |-> en_cp_reg || en_v_reg || en_r_reg;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
    property p_en_rd; s_rd(8'h48) |-> hrdata[7] == en_cp_reg; endproperty
    a_en_rd: assert property (p_en_rd) else $error("enable read");
    property p_st_rd; s_rd(8'h4C) |-> hrdata[6:0] == 7'h00; endproperty
    a_st_rd: assert property (p_st_rd) else $error("status read");
    property p_code_rd; s_rd(8'h58) |-> hrdata[31:7] == 0 && !hrdata[0];
    endproperty
    a_code_rd: assert property (p_code_rd) else $error("code read");
    property p_ctl_rd; s_rd(8'h5C) |-> hrdata[31:5] == 0
        && hrdata[3] == en_r_reg && hrdata[1] == en_v_reg; endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("ctrl read");
    property p_unmap; rd && !(ad_reg inside {8'h48, 8'h4C, 8'h58, 8'h5C})
        |-> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind rxfa_top rxfa_top_chk i_rxfa_top_chk (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cp_err_in(cp_err_in), .msg_stb_in(msg_stb_in),
    .msg_code_in(msg_code_in), .irq_out(irq_out));
